// ### include/itc_pkg.sv
// shared constants of the interrupt throttle and cause-clear block
package itc_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_VEC = 5;
    localparam int TIMER_W = 16;
    localparam int CAUSE_W = 32;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 256;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // advisory ceiling for software, not enforced in hardware
    localparam int MAX_IRQ_PER_SEC = 7813;
    // ==========================================================
    // cause field layout
    localparam int AUTOCLR_LO = 20;
    localparam int AUTOCLR_HI = 24;
    localparam logic [31:0] AUTOCLR_FIELD = 32'h01f0_0000;
    // ==========================================================
    // reset values
    localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] AUTOCLR_RST = 32'h0000_0000;
    localparam logic [15:0] THR_RST = 16'h0000;
endpackage

// ### include/itc_thr_if.sv
// carrier between the cause logic, the tick generator and the vector timers
`timescale 1ns/10ps
interface itc_thr_if #(
    parameter int NUM_VEC = itc_pkg::NUM_VEC,
    parameter int TIMER_W = itc_pkg::TIMER_W
);
    logic tick;
    logic [NUM_VEC-1:0][TIMER_W-1:0] interval;
    logic [NUM_VEC-1:0] pending;
    logic [NUM_VEC-1:0] fire;

    modport tck (output tick);
    modport thr (input tick, input interval, input pending, output fire);
    modport ctl (output interval, output pending, input fire);
endinterface

// ### rtl/itc_tick_gen.sv
// 256 ns tick generator running off the core clock
`timescale 1ns/10ps
module itc_tick_gen (
    input wire logic CLK, // core clock
    input wire logic RESETN, // synchronous reset, active low
    itc_thr_if.tck thr // tick out
);
    localparam int CW = $clog2(itc_pkg::TICK_CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } itc_tick_t;

    itc_tick_t r_ff;
    itc_tick_t nxt_r;

    // ==========================================================
    // prescaler
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tick = 1'b0;
        if (r_ff.cnt == CW'(itc_pkg::TICK_CYC - 1))
        begin
            nxt_r.cnt = '0;
            nxt_r.tick = 1'b1;
        end
        else
        begin
            nxt_r.cnt = r_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign thr.tick = r_ff.tick;
endmodule // itc_tick_gen

// ### rtl/itc_vec_timer.sv
// per-vector countdown throttle timers
`timescale 1ns/10ps
module itc_vec_timer #(
    parameter int NUM_VEC = itc_pkg::NUM_VEC,
    parameter int TIMER_W = itc_pkg::TIMER_W
)(
    input wire logic CLK, // core clock
    input wire logic RESETN, // synchronous reset, active low
    itc_thr_if.thr thr // interval, pending, tick in; fire out
);
    // one spare bit: reload is interval+1 so the gap never falls short
    typedef struct packed {
        logic [NUM_VEC-1:0][TIMER_W:0] cnt;
    } itc_tmr_t;

    itc_tmr_t r_ff;
    itc_tmr_t nxt_r;
    logic [NUM_VEC-1:0] fire_c;

    // ==========================================================
    // countdown
    always_comb
    begin
        nxt_r = r_ff;
        for (int v = 0; v < NUM_VEC; v++)
        begin
            fire_c[v] = (r_ff.cnt[v] == '0) && thr.pending[v];
            if (fire_c[v])
            begin
                if (thr.interval[v] == '0)
                    nxt_r.cnt[v] = '0;
                else
                    nxt_r.cnt[v] = {1'b0, thr.interval[v]} + (TIMER_W + 1)'(1);
            end
            else if (thr.tick && (r_ff.cnt[v] != '0))
            begin
                nxt_r.cnt[v] = r_ff.cnt[v] - (TIMER_W + 1)'(1);
            end
            // idle at zero with nothing pending: counter rests there
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign thr.fire = fire_c;
endmodule // itc_vec_timer

// ### rtl/itc_throttle_clear.sv
// interrupt cause, mask, auto-clear and throttled message issue
//
// Overview of operation
// - outside vector mode, one throttle timer (vector 0) governs every cause.
// - in vector mode each vector has its own timer and mapped causes.
// - throttle interval counts in units of 256 ns.
// - programmed minimum gap between messages holds regardless of traffic.
// - every throttle interval reads zero after reset.
// - each event sets its cause bit at once, whatever the timer state.
// - a vector's message waits until its timer has reached zero.
// - sending a message reloads the timer and restarts the countdown.
// - timer reaching zero with nothing pending stays at zero.
// - an event while the timer rests at zero is sent immediately.
// - auto-clear acts only on causes enabled in auto_clear_enable.
// - after a vector message, enabled causes of that vector clear.
// - writing the cause register clears bits written with one.
// - reading the cause register returns it then clears all bits.
// - only unmasked set causes interrupt; events record regardless of mask.
// - auto-clear on bits 24:20 clears both cause and mask bit.
// - writing one to cause_set sets that cause bit.
// - mask_set sets, mask_clear clears, mask read returns current mask.
`timescale 1ns/10ps
module itc_throttle_clear #(
    parameter int NUM_VEC = itc_pkg::NUM_VEC,
    parameter int TIMER_W = itc_pkg::TIMER_W
)(
    input wire logic CLK, // core clock, 125 MHz
    input wire logic RESETN, // synchronous reset, active low
    input wire logic MSIX_MODE, // 1: per-vector messages, 0: single timer
    input wire logic [31:0] EVENT, // one-cycle cause events, one per bit
    input wire logic [31:0] REG_WDATA, // data for all write strobes
    input wire logic CAUSE_CLR_WR, // write to cause_register, ones clear
    input wire logic CAUSE_RD, // read of cause_register, clears it
    input wire logic CAUSE_SET_WR, // write to cause_set
    input wire logic MASK_SET_WR, // write to mask_set
    input wire logic MASK_CLR_WR, // write to mask_clear
    input wire logic AUTOCLR_WR, // write to auto_clear_enable
    input wire logic THR_WR, // write to vector_throttle_interval[THR_SEL]
    input wire logic [2:0] THR_SEL, // interval select, 0 is throttle_interval
    output logic [31:0] CAUSE_Q, // live cause contents
    output logic [31:0] CAUSE_RDATA, // value returned by last cause read
    output logic [31:0] MASK_Q, // current mask, read of mask_set
    output logic [31:0] AUTOCLR_Q, // auto_clear_enable contents
    output logic [TIMER_W-1:0] THR_RDATA, // interval selected by THR_SEL
    output logic [NUM_VEC-1:0] MSG_FIRE, // one-cycle message request per vector
    output logic INT_PENDING // some unmasked cause is set
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] cause;
        logic [31:0] mask;
        logic [31:0] autoclr;
        logic [NUM_VEC-1:0][TIMER_W-1:0] thr;
        logic [31:0] cause_rd;
        logic [TIMER_W-1:0] thr_rd;
        logic [NUM_VEC-1:0] fire;
        logic pend;
    } itc_regs_t;

    localparam itc_regs_t REGS_RST = '{
        cause: itc_pkg::CAUSE_RST,
        mask: itc_pkg::MASK_RST,
        autoclr: itc_pkg::AUTOCLR_RST,
        thr: {NUM_VEC{TIMER_W'(itc_pkg::THR_RST)}},
        cause_rd: itc_pkg::CAUSE_RST,
        thr_rd: TIMER_W'(itc_pkg::THR_RST),
        fire: '0,
        pend: 1'b0
    };

    itc_regs_t r_ff;
    itc_regs_t nxt_r;

    itc_thr_if #(.NUM_VEC(NUM_VEC), .TIMER_W(TIMER_W)) thr_bus ();

    // ==========================================================
    // cause to vector routing
    // in vector mode, queue causes 20..23 go to vectors 0..3; bit 24 and the legacy
    // non-queue bits all share the last vector
    function automatic logic [31:0] cause_map(input int v, input logic msix);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (!msix)
        begin
            if (v == 0)
                m = 32'hffff_ffff;
        end
        else
        begin
            for (int b = 0; b < 32; b++)
            begin
                if (b >= itc_pkg::AUTOCLR_LO && b <= itc_pkg::AUTOCLR_HI)
                    m[b] = ((b - itc_pkg::AUTOCLR_LO) == v);
                else
                    m[b] = (v == NUM_VEC - 1);
            end
        end
        return m;
    endfunction

    // ==========================================================
    // timers
    itc_tick_gen u_tick (
        .CLK(CLK),
        .RESETN(RESETN),
        .thr(thr_bus.tck)
    );

    itc_vec_timer #(.NUM_VEC(NUM_VEC), .TIMER_W(TIMER_W)) u_timer (
        .CLK(CLK),
        .RESETN(RESETN),
        .thr(thr_bus.thr)
    );

    always_comb
    begin
        for (int v = 0; v < NUM_VEC; v++)
        begin
            thr_bus.interval[v] = r_ff.thr[v];
            thr_bus.pending[v] = |(r_ff.cause & r_ff.mask & cause_map(v, MSIX_MODE));
        end
    end

    // ==========================================================
    // register update
    always_comb
    begin
        logic [31:0] set_c;
        logic [31:0] clr_c;
        logic [31:0] auto_c;
        logic [31:0] mset_c;
        logic [31:0] mclr_c;
        set_c = EVENT;
        clr_c = 32'h0000_0000;
        auto_c = 32'h0000_0000;
        mset_c = 32'h0000_0000;
        mclr_c = 32'h0000_0000;
        nxt_r = r_ff;

        if (CAUSE_SET_WR)
            set_c = set_c | REG_WDATA;
        if (CAUSE_CLR_WR)
            clr_c = clr_c | REG_WDATA;
        if (CAUSE_RD)
            clr_c = 32'hffff_ffff;

        // auto-clear follows a sent vector message only in vector mode
        if (MSIX_MODE)
        begin
            for (int v = 0; v < NUM_VEC; v++)
            begin
                if (thr_bus.fire[v])
                    auto_c = auto_c | (cause_map(v, 1'b1) & r_ff.autoclr);
            end
        end

        // set terms applied last so a same-cycle event survives any clear
        nxt_r.cause = (r_ff.cause & ~(clr_c | auto_c)) | set_c;

        if (MASK_SET_WR)
            mset_c = REG_WDATA;
        if (MASK_CLR_WR)
            mclr_c = REG_WDATA;
        nxt_r.mask = (r_ff.mask & ~(mclr_c | auto_c)) | mset_c;

        // only bits 24:20 can be enabled for auto-clear
        if (AUTOCLR_WR)
            nxt_r.autoclr = REG_WDATA & itc_pkg::AUTOCLR_FIELD;

        if (THR_WR && (int'(THR_SEL) < NUM_VEC))
            nxt_r.thr[THR_SEL] = REG_WDATA[TIMER_W-1:0];

        if (CAUSE_RD)
            nxt_r.cause_rd = r_ff.cause;

        if (int'(THR_SEL) < NUM_VEC)
            nxt_r.thr_rd = r_ff.thr[THR_SEL];
        else
            nxt_r.thr_rd = '0;

        nxt_r.fire = thr_bus.fire;
        nxt_r.pend = |(r_ff.cause & r_ff.mask);
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            r_ff <= REGS_RST;
        else
            r_ff <= nxt_r;
    end

    // ==========================================================
    // outputs
    assign CAUSE_Q = r_ff.cause;
    assign CAUSE_RDATA = r_ff.cause_rd;
    assign MASK_Q = r_ff.mask;
    assign AUTOCLR_Q = r_ff.autoclr;
    assign THR_RDATA = r_ff.thr_rd;
    assign MSG_FIRE = r_ff.fire;
    assign INT_PENDING = r_ff.pend;
endmodule // itc_throttle_clear

// ### verif/itc_props.sv
// checker for the interrupt throttle and cause-clear block
`timescale 1ns/10ps
module itc_props #(
    parameter int NUM_VEC = itc_pkg::NUM_VEC
)(
    input wire logic CLK, // clock
    input wire logic RESETN, // reset
    input wire logic MSIX_MODE, // mode
    input wire logic [31:0] EVENT, // events
    input wire logic [31:0] REG_WDATA, // data
    input wire logic CAUSE_CLR_WR, // cause clear
    input wire logic CAUSE_RD, // cause read
    input wire logic CAUSE_SET_WR, // cause set
    input wire logic MASK_SET_WR, // mask set
    input wire logic MASK_CLR_WR, // mask clear
    input wire logic [31:0] CAUSE_Q, // cause
    input wire logic [31:0] CAUSE_RDATA, // read value
    input wire logic [31:0] MASK_Q, // mask
    input wire logic [31:0] AUTOCLR_Q, // auto-clear enable
    input wire logic [NUM_VEC-1:0] MSG_FIRE, // messages
    input wire logic INT_PENDING // pending
);
    logic pend_c;
    assign pend_c = |(CAUSE_Q & MASK_Q);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    // ==========================================================
    // cause, mask and message relations
    a_event_sets: assert property (EVENT != 32'h0 |=> (CAUSE_Q & $past(EVENT)) == $past(EVENT))
        else $error("event lost");
    a_wr_clears: assert property (CAUSE_CLR_WR && !CAUSE_SET_WR |=>
        (CAUSE_Q & $past(REG_WDATA) & ~$past(EVENT)) == 32'h0) else $error("write-clear failed");
    a_rd_clears: assert property (CAUSE_RD && !CAUSE_SET_WR |=>
        (CAUSE_Q & ~$past(EVENT)) == 32'h0 && CAUSE_RDATA == $past(CAUSE_Q)) else $error("read-clear failed");
    a_set_cause: assert property (CAUSE_SET_WR |=> (CAUSE_Q & $past(REG_WDATA)) == $past(REG_WDATA))
        else $error("cause set failed");
    a_mask_set: assert property (MASK_SET_WR |=> (MASK_Q & $past(REG_WDATA)) == $past(REG_WDATA))
        else $error("mask set failed");
    a_mask_clear: assert property (MASK_CLR_WR && !MASK_SET_WR |=> (MASK_Q & $past(REG_WDATA)) == 32'h0)
        else $error("mask clear failed");
    a_pend_level: assert property (1'b1 |=> INT_PENDING == $past(pend_c))
        else $error("pending wrong");
    a_fire_cause: assert property (MSG_FIRE != '0 |-> $past(pend_c))
        else $error("message without cause");
    a_autoclr_field: assert property ((AUTOCLR_Q & ~itc_pkg::AUTOCLR_FIELD) == 32'h0)
        else $error("auto-clear enable outside its field");
    // vector 0 carries cause bit 20; with no same-cycle set, its message clears cause and mask bit
    a_auto_clear: assert property (MSG_FIRE[0] && $past(MSIX_MODE) && $past(AUTOCLR_Q[20]) &&
        !$past(EVENT[20]) && !$past(CAUSE_SET_WR && REG_WDATA[20]) && !$past(MASK_SET_WR && REG_WDATA[20])
        |-> !CAUSE_Q[20] && !MASK_Q[20]) else $error("auto-clear missed");
endmodule // itc_props
bind itc_throttle_clear itc_props #(.NUM_VEC(NUM_VEC)) u_props (.CLK(CLK), .RESETN(RESETN), .EVENT(EVENT),
    .REG_WDATA(REG_WDATA), .CAUSE_CLR_WR(CAUSE_CLR_WR), .CAUSE_RD(CAUSE_RD), .CAUSE_SET_WR(CAUSE_SET_WR),
    .MASK_SET_WR(MASK_SET_WR), .MASK_CLR_WR(MASK_CLR_WR), .CAUSE_Q(CAUSE_Q), .CAUSE_RDATA(CAUSE_RDATA),
    .MASK_Q(MASK_Q), .MSG_FIRE(MSG_FIRE), .INT_PENDING(INT_PENDING), .MSIX_MODE(MSIX_MODE),
    .AUTOCLR_Q(AUTOCLR_Q));

// ### verif/itc_host_model.sv
// host side: takes interrupt messages and measures their spacing
`timescale 1ns/10ps
module itc_host_model (
    input wire logic clk, // clock
    input wire logic clr, // restart statistics
    input wire logic [4:0] fire, // messages
    input wire logic [31:0] cause, // live cause
    output int cnt [5], // messages per vector
    output int min_gap [5], // shortest spacing, cycles
    output int max_gap [5], // longest spacing, cycles
    output int spurious // vector 0 messages whose cause bit 20 was already gone
);
    int cyc = 0;
    int last [5];
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        // auto-cleared vector finds its cause gone; with no queued work it just exits
        if (clr)
            spurious <= 0;
        else if (fire[0] && cause[20] == 1'b0)
            spurious <= spurious + 1;
        for (int v = 0; v < 5; v++)
        begin
            if (clr)
            begin
                cnt[v] <= 0;
                min_gap[v] <= 1000000;
                max_gap[v] <= 0;
            end
            else if (fire[v])
            begin
                cnt[v] <= cnt[v] + 1;
                last[v] <= cyc;
                if (cnt[v] > 0 && cyc - last[v] < min_gap[v])
                    min_gap[v] <= cyc - last[v];
                if (cnt[v] > 0 && cyc - last[v] > max_gap[v])
                    max_gap[v] <= cyc - last[v];
            end
        end
    end
endmodule // itc_host_model

// ### verif/tb.sv
// self-checking bench for the interrupt throttle and cause-clear block
`timescale 1ns/10ps
module tb;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic msix = 1'b0;
    logic clr = 1'b0;
    logic [31:0] ev = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [6:0] stb = 7'h00;
    logic [2:0] sel = 3'h0;
    logic [31:0] cause_q, cause_rd, mask_q, acl_q;
    logic [15:0] thr_q;
    logic [4:0] fire;
    logic pend;
    int cnt [5];
    int min_gap [5];
    int max_gap [5];
    int spurious;
    int miscompares = 0;
    int comparisons = 0;
    always #4 CLK = ~CLK;
    itc_throttle_clear u_dut (.CLK(CLK), .RESETN(RESETN), .MSIX_MODE(msix), .EVENT(ev), .REG_WDATA(wd),
        .CAUSE_CLR_WR(stb[0]), .CAUSE_RD(stb[1]), .CAUSE_SET_WR(stb[2]), .MASK_SET_WR(stb[3]),
        .MASK_CLR_WR(stb[4]), .AUTOCLR_WR(stb[5]), .THR_WR(stb[6]), .THR_SEL(sel), .CAUSE_Q(cause_q),
        .CAUSE_RDATA(cause_rd), .MASK_Q(mask_q), .AUTOCLR_Q(acl_q), .THR_RDATA(thr_q), .MSG_FIRE(fire),
        .INT_PENDING(pend));
    itc_host_model u_host (.clk(CLK), .clr(clr), .fire(fire), .cause(cause_q), .cnt(cnt), .min_gap(min_gap),
        .max_gap(max_gap), .spurious(spurious));
    // ==========================================================
    // access tasks
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // strobe k: 0 clr-wr, 1 rd, 2 set, 3 mask-set, 4 mask-clr, 5 auto-clear, 6 interval
    task automatic acc(int k, logic [31:0] d);
        @(posedge CLK);
        stb <= 7'h01 << k;
        wd <= d;
        @(posedge CLK);
        stb <= 7'h00;
        #1;
    endtask
    // returns in the cycle where an immediate message shows
    task automatic pulse(logic [31:0] b);
        @(posedge CLK);
        ev <= b;
        @(posedge CLK);
        ev <= 32'h0;
        @(posedge CLK);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial
    begin
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        for (int s = 0; s < 6; s++)
        begin
            @(posedge CLK);
            sel <= 3'(s);
            repeat (2) @(posedge CLK);
            #1;
            chk(32'(thr_q), 32'h0);
        end
        chk(cause_q | mask_q | acl_q, 32'h0);
        $display("test reset done");
        acc(2, 32'h0000_00f0);
        chk(cause_q, 32'h0000_00f0);
        acc(0, 32'h0000_0030);
        chk(cause_q, 32'h0000_00c0);
        acc(1, 32'h0);
        chk(cause_rd, 32'h0000_00c0);
        chk(cause_q, 32'h0);
        @(posedge CLK);
        ev <= 32'h0000_0020;
        stb <= 7'h01;
        wd <= 32'h0000_0020;
        @(posedge CLK);
        ev <= 32'h0;
        stb <= 7'h00;
        #1;
        chk(cause_q, 32'h0000_0020);
        chk(32'(pend), 32'h0);
        acc(3, 32'h0000_0020);
        @(posedge CLK);
        #1;
        chk(32'(pend), 32'h1);
        acc(4, 32'h0000_0020);
        chk(mask_q, 32'h0);
        acc(1, 32'h0);
        $display("test cause done");
        @(posedge CLK);
        msix <= 1'b1;
        sel <= 3'h1;
        acc(6, 32'h0000_0004);
        @(posedge CLK);
        #1;
        chk(32'(thr_q), 32'h4);
        acc(3, 32'h0020_0000);
        @(posedge CLK);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
        ev <= 32'h0020_0000;
        repeat (2) @(posedge CLK);
        #1;
        chk(32'(fire), 32'h2);
        // held event: spacing must stay inside the throttle window
        repeat (760) @(posedge CLK);
        #1;
        chk(32'(min_gap[1] >= 128), 32'h1);
        chk(32'(max_gap[1] <= 162), 32'h1);
        chk(32'(cnt[1] >= 4), 32'h1);
        @(posedge CLK);
        ev <= 32'h0;
        acc(1, 32'h0);
        repeat (200) @(posedge CLK);
        pulse(32'h0020_0000);
        chk(32'(fire), 32'h2);
        acc(0, 32'h0020_0000);
        $display("test throttle done");
        // interval 500 keeps the host under its advised interrupt rate
        @(posedge CLK);
        sel <= 3'h3;
        acc(6, 32'h0000_01f4);
        acc(3, 32'h0080_0000);
        @(posedge CLK);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
        ev <= 32'h0080_0000;
        repeat (16100) @(posedge CLK);
        #1;
        chk(32'(cnt[3]), 32'h2);
        chk(32'(min_gap[3] >= 500 * itc_pkg::TICK_CYC), 32'h1);
        chk(32'(min_gap[3] * itc_pkg::CLK_PERIOD_NS * itc_pkg::MAX_IRQ_PER_SEC >= 1000000000), 32'h1);
        @(posedge CLK);
        ev <= 32'h0;
        acc(1, 32'h0);
        acc(4, 32'h0080_0000);
        $display("test rate limit done");
        acc(5, 32'hffff_ffff);
        chk(acl_q, 32'h01f0_0000);
        acc(5, 32'h0010_0000);
        acc(3, 32'h0050_0000);
        pulse(32'h0050_0000);
        chk(32'(fire & 5'h05), 32'h5);
        chk(cause_q & 32'h0050_0000, 32'h0040_0000);
        chk(mask_q & 32'h0050_0000, 32'h0040_0000);
        acc(4, 32'hffff_ffff);
        acc(1, 32'h0);
        chk(32'(spurious), 32'h1);
        $display("test auto-clear done");
        @(posedge CLK);
        msix <= 1'b0;
        acc(3, 32'h0020_0000);
        pulse(32'h0020_0000);
        chk(32'(fire), 32'h1);
        $display("test single timer done");
        finish_test();
    end
endmodule // tb
